// ### hw/watchdog_down_counter.sv
// Purpose: Watchdog with 32-bit down counter, APB registers and interrupt or reset on timeout.
// Assumes: 125 MHz clock, synchronous active-high reset, ext_clk synchronous to clock.
// Notes: Every APB transfer takes exactly one access cycle.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"
module watchdog_down_counter (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        ext_clk,
	input  wire logic        debug_halt,
	output var  logic        irq,
	output var  logic        sys_reset_req,
	output var  logic        timeout_event
);
	wdt_pkg::cnt_state_t state_ff;
	wdt_pkg::cnt_state_t nxt_state;
	logic [31:0]         load_ff;
	logic [31:0]         cnt_ff;
	logic [31:0]         cnt_view_ff;
	wdt_pkg::prs_sel_t   prs_ff;
	logic                counter_clock_source_select_ff;
	logic                en_ff;
	logic                re_ff;
	logic                ie_ff;
	logic                uf_ff;
	logic                dbg_ff;
	logic [1:0]          stat_ff;
	logic [1:0]          ien_ff;
	logic                irq_ff;
	logic                rst_req_ff;
	logic                tout_ff;
	logic [31:0]         prdata_ff;
	logic                pready_ff;
	logic                pslverr_ff;

	logic [31:0]         nxt_load;
	logic [31:0]         nxt_cnt;
	wdt_pkg::prs_sel_t   nxt_prs;
	logic                nxt_counter_clock_source_select;
	logic                nxt_en;
	logic                nxt_re;
	logic                nxt_ie;
	logic                nxt_uf;
	logic                nxt_dbg;
	logic [1:0]          nxt_stat;
	logic [1:0]          nxt_ien;
	logic                nxt_rst_req;
	logic [31:0]         nxt_prdata;
	logic                nxt_pready;
	logic                nxt_pslverr;

	logic                tick;
	logic                run;
	logic                setup;
	logic                wr;
	logic                load_wr;
	logic                underflow;
	logic [31:0]         ctl_word;

	// Bit 15 set stops counting while the core is halted for debug.
	assign run = en_ff & ~(dbg_ff & debug_halt);

	wdt_prescaler u_prescaler (
		.clock   (clock),
		.sys_rst (sys_rst),
		.ext_clk (ext_clk),
		.src_sel (counter_clock_source_select_ff),
		.prs_sel (prs_ff),
		.run     (run),
		.tick    (tick)
	);

	always_comb begin
		ctl_word                                       = 32'h00000000;
		ctl_word[`WDT_CTL_PRS_MSB:`WDT_CTL_PRS_LSB]    = prs_ff;
		ctl_word[`WDT_CTL_COUNTER_CLOCK_SOURCE_SELECT]                       = counter_clock_source_select_ff;
		ctl_word[`WDT_CTL_EN]                          = en_ff;
		ctl_word[`WDT_CTL_RE]                          = re_ff;
		ctl_word[`WDT_CTL_IE]                          = ie_ff;
		ctl_word[`WDT_CTL_UF]                          = uf_ff;
		ctl_word[`WDT_CTL_DBG]                         = dbg_ff;
	end

	// APB: setup phase registers read data and ready, access phase commits writes.
	always_comb begin
		setup       = psel & ~penable;
		wr          = psel & penable & pwrite & pready_ff;
		load_wr     = wr & (paddr == `WDT_OFS_LOAD);
		nxt_pready  = setup;
		nxt_pslverr = 1'b0;
		nxt_prdata  = prdata_ff;
		if (setup) begin
			nxt_prdata = 32'h00000000;
			unique case (paddr)
				`WDT_OFS_LOAD:  nxt_prdata = pwrite ? 32'h00000000 : load_ff;
				`WDT_OFS_COUNT: nxt_prdata = pwrite ? 32'h00000000 : cnt_view_ff;
				`WDT_OFS_CTRL:  nxt_prdata = pwrite ? 32'h00000000 : ctl_word;
				`WDT_OFS_STAT:  nxt_prdata = pwrite ? 32'h00000000 : {30'h0, stat_ff};
				`WDT_OFS_CLR:   nxt_prdata = 32'h00000000;
				`WDT_OFS_IEN:   nxt_prdata = pwrite ? 32'h00000000 : {30'h0, ien_ff};
				default:        nxt_pslverr = 1'b1;
			endcase
		end
	end

	// Control and load registers; the live count has no write path.
	always_comb begin
		nxt_load  = load_ff;
		nxt_prs   = prs_ff;
		nxt_counter_clock_source_select = counter_clock_source_select_ff;
		nxt_en    = en_ff;
		nxt_re    = re_ff;
		nxt_ie    = ie_ff;
		nxt_dbg   = dbg_ff;
		nxt_ien   = ien_ff;
		if (load_wr) begin
			nxt_load = pwdata;
		end
		if (wr && paddr == `WDT_OFS_CTRL) begin
			nxt_prs   = pwdata[`WDT_CTL_PRS_MSB:`WDT_CTL_PRS_LSB];
			nxt_counter_clock_source_select = pwdata[`WDT_CTL_COUNTER_CLOCK_SOURCE_SELECT];
			nxt_en    = pwdata[`WDT_CTL_EN];
			nxt_re    = pwdata[`WDT_CTL_RE];
			nxt_ie    = pwdata[`WDT_CTL_IE];
			nxt_dbg   = pwdata[`WDT_CTL_DBG];
		end
		if (wr && paddr == `WDT_OFS_IEN) begin
			nxt_ien = pwdata[1:0];
		end
	end

	// Counter state machine.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		underflow = 1'b0;
		unique case (state_ff)
			wdt_pkg::st_stop: begin
				if (en_ff) begin
					nxt_cnt   = load_ff;
					nxt_state = wdt_pkg::st_count;
				end
			end
			wdt_pkg::st_count: begin
				if (!en_ff) begin
					nxt_state = wdt_pkg::st_stop;
				end else if (tick) begin
					if (cnt_ff <= 32'h00000001) begin
						nxt_cnt   = 32'h00000000;
						underflow = 1'b1;
						nxt_state = ie_ff ? wdt_pkg::st_reload : wdt_pkg::st_expired;
					end else begin
						nxt_cnt = cnt_ff - 32'h00000001;
					end
				end
			end
			wdt_pkg::st_reload: begin
				nxt_cnt   = load_ff;
				nxt_state = en_ff ? wdt_pkg::st_count : wdt_pkg::st_stop;
			end
			wdt_pkg::st_expired: begin
				if (!en_ff) begin
					nxt_state = wdt_pkg::st_stop;
				end
			end
		endcase
		// A kick while enabled restarts the count from the written value.
		if (load_wr && en_ff) begin
			nxt_cnt   = pwdata;
			nxt_state = wdt_pkg::st_count;
		end
	end

	// Events: hardware set wins over a same-cycle clear.
	always_comb begin
		nxt_uf = underflow | (uf_ff & ~load_wr);
		nxt_stat = stat_ff;
		if (wr && paddr == `WDT_OFS_CLR) begin
			nxt_stat = stat_ff & ~pwdata[1:0];
		end
		nxt_stat[`WDT_ST_IRQ] = nxt_stat[`WDT_ST_IRQ] | (underflow & ie_ff);
		nxt_stat[`WDT_ST_RST] = nxt_stat[`WDT_ST_RST] | (underflow & re_ff);
		// The reset request stays up until the system reset arrives.
		nxt_rst_req = rst_req_ff | (underflow & re_ff);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_ff    <= wdt_pkg::st_count;
			load_ff     <= `WDT_RST_LOAD;
			cnt_ff      <= `WDT_RST_COUNT;
			cnt_view_ff <= `WDT_RST_COUNT;
			prs_ff      <= 3'(`WDT_RST_CTRL >> `WDT_CTL_PRS_LSB);
			counter_clock_source_select_ff    <= 1'(`WDT_RST_CTRL >> `WDT_CTL_COUNTER_CLOCK_SOURCE_SELECT);
			en_ff       <= 1'(`WDT_RST_CTRL >> `WDT_CTL_EN);
			re_ff       <= 1'(`WDT_RST_CTRL >> `WDT_CTL_RE);
			ie_ff       <= 1'(`WDT_RST_CTRL >> `WDT_CTL_IE);
			uf_ff       <= 1'(`WDT_RST_CTRL >> `WDT_CTL_UF);
			dbg_ff      <= 1'(`WDT_RST_CTRL >> `WDT_CTL_DBG);
			stat_ff     <= 2'h0;
			ien_ff      <= 2'h0;
			irq_ff      <= 1'b0;
			rst_req_ff  <= 1'b0;
			tout_ff     <= 1'b0;
			prdata_ff   <= 32'h00000000;
			pready_ff   <= 1'b0;
			pslverr_ff  <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			load_ff     <= nxt_load;
			cnt_ff      <= nxt_cnt;
			cnt_view_ff <= cnt_ff;
			prs_ff      <= nxt_prs;
			counter_clock_source_select_ff    <= nxt_counter_clock_source_select;
			en_ff       <= nxt_en;
			re_ff       <= nxt_re;
			ie_ff       <= nxt_ie;
			uf_ff       <= nxt_uf;
			dbg_ff      <= nxt_dbg;
			stat_ff     <= nxt_stat;
			ien_ff      <= nxt_ien;
			irq_ff      <= |(stat_ff & ien_ff);
			rst_req_ff  <= nxt_rst_req;
			tout_ff     <= underflow;
			prdata_ff   <= nxt_prdata;
			pready_ff   <= nxt_pready;
			pslverr_ff  <= nxt_pslverr;
		end
	end

	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign irq           = irq_ff;
	assign sys_reset_req = rst_req_ff;
	assign timeout_event = tout_ff;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	chk_count_step: assert property (
		state_ff == wdt_pkg::st_count && en_ff && tick && cnt_ff > 32'h1 && !load_wr
		|=> cnt_ff == $past(cnt_ff) - 32'h1)
		else $error("counter did not step down by one on a tick");

	chk_count_hold: assert property (
		state_ff == wdt_pkg::st_count && !tick && !load_wr |=> cnt_ff == $past(cnt_ff))
		else $error("counter moved without a tick");

	chk_load_copy: assert property (
		load_wr && en_ff |=> cnt_ff == $past(pwdata) && state_ff == wdt_pkg::st_count)
		else $error("enabled load write did not reach the counter");

	chk_load_blocked: assert property (
		load_wr && !en_ff && state_ff == wdt_pkg::st_stop |=> cnt_ff == $past(cnt_ff))
		else $error("disabled load write changed the counter");

	chk_auto_reload: assert property (
		underflow && ie_ff && en_ff && !load_wr |-> ##[1:5] cnt_ff == load_ff)
		else $error("interrupt mode reload took too long");

	chk_reset_request: assert property (
		underflow && re_ff |=> sys_reset_req && timeout_event)
		else $error("reset request missing after underflow");

	chk_uf_flag: assert property (
		underflow |=> uf_ff)
		else $error("underflow flag not set");

	chk_uf_clear: assert property (
		load_wr && !underflow |=> !uf_ff)
		else $error("load write did not clear the underflow flag");

	chk_irq_raise: assert property (
		underflow && ie_ff && ien_ff[`WDT_ST_IRQ] && !wr |-> ##2 irq)
		else $error("enabled timeout did not raise the interrupt");

	chk_apb_ready: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("apb ready not a single access-phase pulse");

	chk_stop_start: assert property (
		state_ff == wdt_pkg::st_stop && en_ff && !load_wr
		|=> state_ff == wdt_pkg::st_count && cnt_ff == $past(load_ff))
		else $error("enable did not start the count from the load value");

	chk_expired_hold: assert property (
		state_ff == wdt_pkg::st_expired && en_ff && !load_wr |=> cnt_ff == 32'h00000000)
		else $error("expired counter left zero without a load write");

	chk_irq_follow: assert property (
		irq == $past(|(stat_ff & ien_ff)))
		else $error("interrupt output does not follow the enabled status");

	chk_rst_sticky: assert property (
		sys_reset_req |=> sys_reset_req)
		else $error("reset request dropped before the system reset");

	chk_slverr_map: assert property (
		psel && !penable && paddr > `WDT_OFS_IEN |=> pready && pslverr)
		else $error("unmapped address not answered with an error");
endmodule : watchdog_down_counter
`default_nettype wire

// ### hw/wdt_pkg.sv
// Purpose: Shared types of the watchdog.
// Assumes: Constants live in wdt_regs.svh.
// Notes: States are one-hot.
package wdt_pkg;
	typedef enum logic [3:0] {
		st_stop    = 4'h1,
		st_count   = 4'h2,
		st_reload  = 4'h4,
		st_expired = 4'h8
	} cnt_state_t;

	typedef logic [2:0] prs_sel_t;
endpackage : wdt_pkg

// ### hw/wdt_prescaler.sv
// Purpose: Counter tick generator: source select and divide by 1, 4, 8 .. 256.
// Assumes: ext_clk is a slow level synchronous to clock.
// Notes: The tick is a one-cycle enable; the counter stays on the single clock.
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler (
	input  wire logic            clock,
	input  wire logic            sys_rst,
	input  wire logic            ext_clk,
	input  wire logic            src_sel,
	input  wire wdt_pkg::prs_sel_t prs_sel,
	input  wire logic            run,
	output var  logic            tick
);
	logic       ext_q_ff;
	logic [7:0] div_ff;
	logic       tick_ff;
	logic       nxt_ext_q;
	logic [7:0] nxt_div;
	logic       nxt_tick;
	logic       src_tick;
	logic [7:0] term;

	always_comb begin
		nxt_ext_q = ext_clk;
		src_tick  = src_sel ? (ext_clk & ~ext_q_ff) : 1'b1;
		if (prs_sel == 3'h0) begin
			term = 8'h00;
		end else begin
			term = 8'((9'h001 << ({1'b0, prs_sel} + 4'h1)) - 9'h001);
		end
		nxt_div  = div_ff;
		nxt_tick = 1'b0;
		if (!run) begin
			nxt_div = 8'h00;
		end else if (src_tick) begin
			if (div_ff >= term) begin
				nxt_div  = 8'h00;
				nxt_tick = 1'b1;
			end else begin
				nxt_div = div_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Starting high keeps a pin that is already high at release from counting as an edge.
			ext_q_ff <= 1'b1;
			div_ff   <= 8'h00;
			tick_ff  <= 1'b0;
		end else begin
			ext_q_ff <= nxt_ext_q;
			div_ff   <= nxt_div;
			tick_ff  <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule : wdt_prescaler
`default_nettype wire

// ### hw/wdt_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:
// Summary of operation
// - The timeout counter is 32 bits wide and counts down once per prescaled tick while enabled.
// - A timeout can answer with a periodic interrupt request or with a system reset request.
// - Load value sits at 0x0000, live count at 0x0004 and control at 0x0008.
// - Reset values are load 0x00000000, count 0x0000FFFF and control 0x0000805C.
// - Untouched after reset the first timeout comes after about two thousand milliseconds.
// - A load value write copies into the counter only while the counting enable bit is one.
// - The live count register is read-only and returns the running counter value.
// - Reaching zero triggers whichever response is enabled, interrupt or reset.
// - After a load the counter goes on down from the value just written.
// - The counter base clock and its divider are chosen by control register fields.
// - A dedicated output flags each timeout event to surrounding logic.
// - Setting control bit 4 starts counting from the load value.
// - With control bit 6 set an underflow to zero asserts a system reset request.
// - Underflow sets a pending flag that any load value write clears.
// - In interrupt mode the counter reloads after underflow within five cycles.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define WDT_OFS_LOAD     8'h00
`define WDT_OFS_COUNT    8'h04
`define WDT_OFS_CTRL     8'h08
`define WDT_OFS_STAT     8'h0C
`define WDT_OFS_CLR      8'h10
`define WDT_OFS_IEN      8'h14

`define WDT_CTL_PRS_LSB  0
`define WDT_CTL_PRS_MSB  2
`define WDT_CTL_COUNTER_CLOCK_SOURCE_SELECT    3
`define WDT_CTL_EN       4
`define WDT_CTL_RE       6
`define WDT_CTL_IE       7
`define WDT_CTL_UF       8
`define WDT_CTL_DBG      15

`define WDT_ST_IRQ       0
`define WDT_ST_RST       1

`define WDT_RST_LOAD     32'h00000000
`define WDT_RST_COUNT    32'h0000FFFF
`define WDT_RST_CTRL     32'h0000805C

`define WDT_RELOAD_MAX   5

`endif

// ### verification/tb.sv
// Purpose: Self-checking bench for the watchdog down counter.
// Assumes: The APB master waits for pready; prescale 000 gives a tick every clock.
// Notes: Timeout windows allow a few cycles, since the prescaler phase runs free.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r, a;
	logic        pready, pslverr, e, irq, sys_reset_req, timeout_event;
	logic        ext_clk = 1'b0, debug_halt = 1'b0, ext_run = 1'b0;
	int          n_fail = 0, samples_checked = 0, cyc = 0, n, ld, ph = 0;
	int          divs[8] = '{1, 4, 8, 16, 32, 64, 128, 256};

	watchdog_down_counter i_watchdog_down_counter (.clock(clock), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
		.debug_halt(debug_halt), .irq(irq), .sys_reset_req(sys_reset_req),
		.timeout_event(timeout_event));

	always #4 clock = ~clock;

	// The external clock is a slow level, so it only changes on the system clock.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		ph <= (ph + 1) % 4;
		if (ext_run && ph == 3) begin
			ext_clk <= ~ext_clk;
		end
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			tally_and_finish();
		end
	end

	task tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk

	// Vectors, not ints, so that an unknown value fails instead of reading as zero.
	task rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		chk(32'h1, {31'h0, (v >= lo && v <= hi)});
	endtask : rng

	// Request is held from setup until pready is seen high at a rising edge, then released there.
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wait_out(input logic rst_kind, output int k);
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (((rst_kind ? sys_reset_req : timeout_event) !== 1'b1) && k < 3000);
	endtask : wait_out

	initial begin
		void'($urandom(32'h8661));
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0); chk(32'h0, r);
		apb(1'b0, 8'h08, 32'h0); chk(32'h805C, r);
		apb(1'b0, 8'h04, 32'h0); chk(32'hFFFF, r);
		apb(1'b1, 8'h04, 32'h1234);
		apb(1'b0, 8'h04, 32'h0); chk(32'hFFFF, r);
		apb(1'b0, 8'h40, 32'h0); chk(32'h1, {31'h0, e});
		$display("test reset_map done");
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, 8'h08, 32'h10 | p);
			apb(1'b1, 8'h00, 32'h3);
			wait_out(1'b0, n); rng(n, 2 * divs[p], 4 * divs[p] + 6);
			apb(1'b0, 8'h04, 32'h0); chk(32'h0, r);
			apb(1'b0, 8'h08, 32'h0); chk(32'h110 | p, r);
		end
		$display("test prescale done");
		ld = 20 + $urandom % 40;
		apb(1'b1, 8'h14, 32'h1);
		apb(1'b1, 8'h08, 32'h90);
		apb(1'b1, 8'h00, ld);
		wait_out(1'b0, n); rng(n, ld - 1, ld + 6);
		repeat (2) @(negedge clock);
		chk(32'h1, {31'h0, irq});
		apb(1'b0, 8'h0C, 32'h0); chk(32'h1, r);
		apb(1'b0, 8'h04, 32'h0); rng(r, ld - 12, ld);
		apb(1'b1, 8'h10, 32'h1);
		repeat (2) @(negedge clock);
		chk(32'h0, {31'h0, irq});
		apb(1'b1, 8'h00, 32'h1000);
		apb(1'b0, 8'h08, 32'h0); chk(32'h90, r);
		apb(1'b0, 8'h04, 32'h0); rng(r, 32'hFF0, 32'h1000);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h00, ld);
		wait_out(1'b0, n); rng(n, ld - 1, ld + 6);
		repeat (3) @(negedge clock);
		chk(32'h0, {31'h0, irq});
		apb(1'b0, 8'h0C, 32'h0); chk(32'h1, r);
		apb(1'b1, 8'h10, 32'h1);
		$display("test interrupt done");
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h00, 32'h77);
		apb(1'b0, 8'h04, 32'h0); a = r; rng(a, 0, ld);
		repeat (6) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0); chk(a, r);
		apb(1'b1, 8'h08, 32'h10);
		// The count readback lags the counter, so let the start from the load value show first.
		repeat (2) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0); rng(r, 32'h6F, 32'h77);
		$display("test enable done");
		apb(1'b1, 8'h08, 32'h18);
		apb(1'b1, 8'h00, 32'h100);
		ext_run <= 1'b1;
		apb(1'b0, 8'h04, 32'h0); a = r;
		repeat (40) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0); rng(a - r, 1, 12);
		ext_run <= 1'b0;
		$display("test external_clock done");
		apb(1'b1, 8'h08, 32'h8010);
		debug_halt <= 1'b1;
		apb(1'b0, 8'h04, 32'h0); a = r;
		repeat (8) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0); chk(a, r);
		debug_halt <= 1'b0;
		repeat (4) @(posedge clock);
		apb(1'b0, 8'h04, 32'h0); rng(a - r, 1, 12);
		$display("test debug_stop done");
		apb(1'b1, 8'h08, 32'h50);
		apb(1'b1, 8'h00, ld);
		wait_out(1'b1, n); rng(n, ld - 1, ld + 6);
		repeat (20) @(negedge clock);
		chk(32'h1, {31'h0, sys_reset_req});
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		chk(32'h0, {31'h0, sys_reset_req});
		apb(1'b0, 8'h08, 32'h0); chk(32'h805C, r);
		$display("test reset_mode done");
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
